// File: design/fdc_divider_chain.sv
// divider chain: staged register bytes, phase accumulator, output dividers
// Functional notes
// R01: the output clock is the oscillator divided by high and low ratios.
// R02: the oscillator rate is the reference times the feedback ratio; the model gives oscillator edges at ratio / 2^11 of mclk instead.
// R03: the feedback ratio is 43-bit unsigned 11.32 fixed point.
// R04: the host keeps high ratio 4..2046 and feedback code in its limits.
// R05: the high-speed divider is an integer 11-bit unsigned ratio.
// R06: small high ratios may be odd and keep a 50% duty cycle.
// R07: the host programs only even high ratios from 34 upward.
// R08: the low divider divides by two to a 3-bit exponent, 1 to 32.
// R09: exponent 6 or 7 divides by 32.
// R10: all divider fields are read as unsigned values.
// R11: the host keeps the oscillator in its legal band.
// R12: the host prefers odd high ratios when the low ratio is one.
// R13: the packed byte holds exponent in 6:4 and high bits 10:8 in 2:0.
// R14: the host scales the fraction by two to the 32nd and truncates.
// R15: new divider values take effect only on a complete update.
`timescale 1ns/1ps
`include "fdc_consts.svh"
module fdc_divider_chain (
    input wire logic mclk,
    input wire logic rst_n,
    input wire fdc_pkg::fdc_wr_t wr,
    input wire logic apply,
    output logic [7:0] rd_data,
    input wire logic [7:0] rd_addr,
    output logic osc_clk,
    output logic clk_out
);
    // ----------------------------------------------------------------
    // staging bytes written by the host
    // ----------------------------------------------------------------
    fdc_pkg::fdc_div_t stage_reg;
    fdc_pkg::fdc_div_t active_reg;
    wire hit_hs = wr.wr && wr.addr == `FDC_IDX_HS_LO;
    wire hit_pk = wr.wr && wr.addr == `FDC_IDX_PACKED;
    wire [2:0] fb_sel = 3'(wr.addr - `FDC_IDX_FB0);
    wire hit_fb = wr.wr && wr.addr >= `FDC_IDX_FB0 &&
        wr.addr <= `FDC_IDX_FB5;
    // byte writes land only in staging
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stage_reg <= '0;
        end else begin
            if (hit_hs) begin
                stage_reg.hs[7:0] <= wr.data;
            end
            if (hit_pk) begin
                stage_reg.ls <= wr.data[`FDC_PK_LS_HI:`FDC_PK_LS_LO]; // [R13]
                stage_reg.hs[10:8] <=
                    wr.data[`FDC_PK_HS_HI:`FDC_PK_HS_LO]; // [R13]
            end
            if (hit_fb) begin
                if (fb_sel == 3'h5) begin
                    stage_reg.fb[42:40] <= wr.data[2:0];
                end else begin
                    stage_reg.fb[fb_sel*8 +: 8] <= wr.data;
                end
            end
        end
    end
    // whole set moves at once, never a partial field
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            active_reg <= '0;
        end else if (apply) begin
            active_reg <= stage_reg; // [R15]
        end
    end
    // ----------------------------------------------------------------
    // readback of staged bytes; unused bits read zero
    // ----------------------------------------------------------------
    // staging is shown rather than the live set, so a host can check a
    // whole load before it applies it
    wire [2:0] rd_sel = 3'(rd_addr - `FDC_IDX_FB0);
    wire [47:0] fb_pad = {5'h00, stage_reg.fb};
    wire [7:0] rd_next =
        (rd_addr == `FDC_IDX_HS_LO) ? stage_reg.hs[7:0] :
        (rd_addr == `FDC_IDX_PACKED) ?
            {1'b0, stage_reg.ls, 1'b0, stage_reg.hs[10:8]} :
        (rd_addr >= `FDC_IDX_FB0 && rd_addr <= `FDC_IDX_FB5) ?
            fb_pad[rd_sel*8 +: 8] : 8'h00;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_next;
        end
    end
    // ----------------------------------------------------------------
    // oscillator model: 11.32 phase accumulator on the reference tick
    // ----------------------------------------------------------------
    // mclk stands for the reference; a true multiply needs analog, so
    // the whole 11.32 ratio is added each cycle and the carry out of the
    // top bit is one oscillator edge: edge rate is ratio / 2^11 of mclk.
    // the fraction is kept, so fine steps still move the mean rate.
    // limitation: the model runs far below the reference, never above
    logic [`FDC_FB_W-1:0] phase_reg;
    wire [`FDC_FB_W:0] phase_sum = {1'b0, phase_reg} +
        {1'b0, active_reg.fb}; // [R02] [R03] [R10]
    wire osc_tick = phase_sum[`FDC_FB_W]; // carry out [R02]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phase_reg <= '0;
            osc_clk <= 1'b0;
        end else begin
            phase_reg <= phase_sum[`FDC_FB_W-1:0];
            if (osc_tick) begin
                osc_clk <= ~osc_clk;
            end
        end
    end
    // ----------------------------------------------------------------
    // high-speed divider: counts oscillator half periods (edges)
    // ----------------------------------------------------------------
    // counting both edges gives 50% duty even for odd ratios
    // each half period is a whole number of oscillator edges, so no
    // separate correction path is needed; ratios under 4 are held at 4
    // apply restarts both dividers, so a smaller new ratio never leaves
    // a counter stranded above its wrap point for a full roll-over
    wire div_restart = apply; // [R15]
    logic [`FDC_HS_W-1:0] hs_cnt_reg;
    logic hs_clk;
    wire [`FDC_HS_W-1:0] hs_ratio = (active_reg.hs < `FDC_HS_MIN) ?
        `FDC_HS_MIN : active_reg.hs; // [R05] [R10]
    wire hs_wrap = hs_cnt_reg == hs_ratio - 11'h001;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hs_cnt_reg <= '0;
            hs_clk <= 1'b0;
        end else if (div_restart) begin
            hs_cnt_reg <= '0; // [R15]
        end else if (osc_tick) begin
            hs_cnt_reg <= hs_wrap ? '0 : hs_cnt_reg + 11'h001; // [R06]
            if (hs_wrap) begin
                hs_clk <= ~hs_clk; // [R01] [R06]
            end
        end
    end
    wire hs_tick = osc_tick && hs_wrap && !div_restart;
    // ----------------------------------------------------------------
    // low-speed divider: power of two, clamped at 32
    // ----------------------------------------------------------------
    wire [2:0] ls_exp = (active_reg.ls > `FDC_LS_MAX_EXP) ?
        `FDC_LS_MAX_EXP : active_reg.ls; // [R09]
    logic [4:0] ls_cnt_reg;
    wire [5:0] ls_ratio = 6'h01 << ls_exp; // [R08]
    wire ls_wrap = {1'b0, ls_cnt_reg} == ls_ratio - 6'h01;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ls_cnt_reg <= 5'h00;
            clk_out <= 1'b0;
        end else if (div_restart) begin
            ls_cnt_reg <= 5'h00; // [R15]
        end else if (hs_tick) begin
            ls_cnt_reg <= ls_wrap ? 5'h00 : ls_cnt_reg + 5'h01;
            if (ls_wrap) begin
                clk_out <= ~clk_out; // [R01]
            end
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence apply_s;
        apply;
    endsequence
    // ----------------------------------------------------------------
    // named steps of a load and a readback
    // ----------------------------------------------------------------
    // write of the top feedback byte, only three bits of it are kept
    sequence fb_top_wr_s;
        hit_fb && fb_sel == 3'h5;
    endsequence
    // readback request of the packed byte
    sequence pk_rd_s;
        rd_addr == `FDC_IDX_PACKED;
    endsequence
    stage_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(apply) |-> active_reg == $past(active_reg)) // [R15]
        else $error("active set changed without apply");
    apply_copy_a: assert property (@(posedge mclk) disable iff (!rst_n)
        apply_s |=> active_reg == $past(stage_reg)) // [R15]
        else $error("apply did not copy staging");
    packed_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
        hit_pk |=> stage_reg.ls == $past(wr.data[6:4]) &&
        stage_reg.hs[10:8] == $past(wr.data[2:0])) // [R13]
        else $error("packed byte mapped wrong");
    ls_clamp_a: assert property (@(posedge mclk) disable iff (!rst_n)
        active_reg.ls > 3'h5 |-> ls_ratio == 6'h20) // [R09]
        else $error("low exponent not clamped to 32");
    ls_pow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        active_reg.ls <= 3'h5 |-> ls_ratio == (6'h01 << active_reg.ls))
        else $error("low ratio not a power of two"); // [R08]
    hs_toggle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        hs_tick |=> hs_clk != $past(hs_clk)) // [R06]
        else $error("high divider did not toggle at wrap");
    hs_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
        hs_cnt_reg < hs_ratio || $changed(active_reg)) // [R05]
        else $error("high counter past ratio");
    out_stable_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(hs_tick) |-> clk_out == $past(clk_out)) // [R01]
        else $error("output moved without high tick");
    osc_rate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(osc_tick) |-> osc_clk == $past(osc_clk)) // [R02]
        else $error("oscillator moved without tick");
    hs_low_map_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
        hit_hs |=> stage_reg.hs[7:0] == $past(wr.data))
        else $error("high divider low byte mapped wrong");
    fb_top_map_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R03]
        fb_top_wr_s |=> stage_reg.fb[42:40] == $past(wr.data[2:0]))
        else $error("feedback top bits mapped wrong");
    fb_low_map_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R03]
        hit_fb && fb_sel == 3'h0 |=> stage_reg.fb[7:0] == $past(wr.data))
        else $error("feedback low byte mapped wrong");
    div_restart_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
        apply_s |=> hs_cnt_reg == '0 && ls_cnt_reg == 5'h00)
        else $error("dividers not restarted by apply");
    pack_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
        pk_rd_s |=> rd_data[7] == 1'b0 && rd_data[3] == 1'b0)
        else $error("unused packed bits not zero");
    ls_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R01]
        hs_tick && ls_wrap |=> clk_out != $past(clk_out))
        else $error("output did not toggle at low wrap");
    osc_idle_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R02]
        active_reg.fb == '0 |-> !osc_tick)
        else $error("oscillator ran with zero ratio");
endmodule : fdc_divider_chain

// File: design/fdc_consts.svh
// constants for the frequency divider chain
`ifndef FDC_CONSTS_SVH
`define FDC_CONSTS_SVH
// ----------------------------------------------------------------
// field widths and positions
// ----------------------------------------------------------------
`define FDC_FB_W 43
`define FDC_FB_INT_W 11
`define FDC_FB_FRAC_W 32
`define FDC_HS_W 11
`define FDC_LS_W 3
`define FDC_LS_MAX_EXP 3'h5
`define FDC_PK_LS_HI 6
`define FDC_PK_LS_LO 4
`define FDC_PK_HS_HI 2
`define FDC_PK_HS_LO 0
`define FDC_HS_HI_LSB 8
`define FDC_HS_ODD_MAX 11'h021
`define FDC_HS_MIN 11'h004
// ----------------------------------------------------------------
// register indices, one byte each
// ----------------------------------------------------------------
`define FDC_IDX_HS_LO 8'h17
`define FDC_IDX_PACKED 8'h18
`define FDC_IDX_FB0 8'h1A
`define FDC_IDX_FB5 8'h1F
`endif

// File: design/fdc_pkg.sv
// types of the frequency divider chain
package fdc_pkg;
    // ----------------------------------------------------------------
    // divider settings carried as one group
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [42:0] fb;
        logic [10:0] hs;
        logic [2:0] ls;
    } fdc_div_t;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } fdc_wr_t;
endpackage : fdc_pkg

// File: dv/fdc_host_model.sv
// host model that loads divider settings byte by byte
`timescale 1ns/1ps
module fdc_host_model (
    input wire logic mclk,
    output fdc_pkg::fdc_wr_t wr,
    output logic apply
);
    initial begin
        wr = '0;
        apply = 1'b0;
    end
    // strobe stays high across back to back bytes
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= '{wr: 1'b1, addr: a, data: d};
    endtask : put
    task automatic idle();
        @(posedge mclk);
        wr <= '0;
    endtask : idle
    // caller keeps hs in 4..2046, odd only up to 33, fb in its band
    task automatic load(input logic [42:0] fb, input logic [10:0] hs,
                        input logic [2:0] ls, input logic go);
        put(8'h17, hs[7:0]);
        put(8'h18, {1'b0, ls, 1'b0, hs[10:8]});
        for (int i = 0; i < 5; i++) begin
            put(8'h1A + 8'(i), fb[8*i +: 8]);
        end
        put(8'h1F, {5'h00, fb[42:40]});
        // apply only after the last byte, so no half-written set is used
        @(posedge mclk);
        wr <= '0;
        apply <= go;
        @(posedge mclk);
        apply <= 1'b0;
    endtask : load
endmodule : fdc_host_model

// File: dv/test_frequency_divider_chain.sv
// self-checking bench for the frequency divider chain
`timescale 1ns/1ps
module test_frequency_divider_chain;
    logic mclk, rst_n, osc_clk, clk_out, osc_q, out_q, apply;
    logic [7:0] rd_addr, rd_data, b;
    logic [15:0] per, mper;
    logic [42:0] fb;
    fdc_pkg::fdc_wr_t wr;
    int fail_count, checks, cyc, run, nper, mrun;
    fdc_divider_chain i_dut (.mclk(mclk), .rst_n(rst_n), .wr(wr),
        .apply(apply), .rd_data(rd_data), .rd_addr(rd_addr),
        .osc_clk(osc_clk), .clk_out(clk_out));
    fdc_host_model i_host (.mclk(mclk), .wr(wr), .apply(apply));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // period meter: oscillator rises per output period, plus watchdog
    always @(posedge mclk) begin
        cyc = cyc + 1;
        mrun = mrun + 1;
        if (osc_clk === 1'b1 && osc_q === 1'b0) run = run + 1;
        if (clk_out === 1'b1 && out_q === 1'b0) begin
            per = run[15:0];
            mper = mrun[15:0];
            nper = nper + 1;
            run = 0;
            mrun = 0;
        end
        osc_q = osc_clk;
        out_q = clk_out;
        if (cyc == 90000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk_byte
    task automatic chk_per(input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk_per
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        rd_addr <= a;
        @(posedge mclk);
        #1 b = rd_data;
    endtask : rd
    // two period ends, so the one cut by apply is not judged
    task automatic wait_per();
        int n0;
        n0 = nper;
        while (nper < n0 + 2) @(posedge mclk);
    endtask : wait_per
    task automatic t_readback();
        fb = 43'h047E756E62A;
        i_host.load(fb, 11'h046, 3'h0, 1'b1);
        rd(8'h17);
        chk_byte(8'h46, b);
        for (int i = 0; i < 5; i++) begin
            rd(8'h1A + 8'(i));
            chk_byte(fb[8*i +: 8], b);
        end
        i_host.put(8'h18, 8'hFF);
        i_host.idle();
        rd(8'h18);
        chk_byte(8'h77, b);
    endtask : t_readback
    // odd ratios, exponent clamp at 32, then a load held back by apply
    task automatic t_period();
        logic [10:0] hs_t[5] = '{11'h004, 11'h005, 11'h006, 11'h021,
            11'h004};
        logic [2:0] ls_t[5] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h6};
        logic [15:0] exp_per;
        fb = 43'h03C00000000;
        for (int i = 0; i < 5; i++) begin
            i_host.load(fb, hs_t[i], ls_t[i], 1'b1);
            wait_per();
            exp_per = {5'h00, hs_t[i]} << (ls_t[i] > 3'h5 ? 5 : ls_t[i]);
            chk_per(exp_per, per);
        end
        i_host.load(fb, 11'h006, 3'h0, 1'b0);
        wait_per();
        chk_per(16'h0080, per);
        i_host.load(fb, 11'h006, 3'h0, 1'b1);
        wait_per();
        chk_per(16'h0006, per);
        // ratio 1024.0 gives an oscillator edge every second mclk, so a
        // divide by 4 must span exactly 16 mclk cycles
        i_host.load(43'h40000000000, 11'h004, 3'h0, 1'b1);
        wait_per();
        chk_per(16'h0010, mper);
    endtask : t_period
    initial begin
        {rst_n, rd_addr, cyc, run, nper, mrun, fail_count, checks} = '0;
        {osc_q, out_q, per, mper, b} = '0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_readback();
        t_period();
        give_verdict();
    end
endmodule : test_frequency_divider_chain
